// File: gpio_port.sv
// Bit-programmable I/O port with a classic Wishbone register slave.
// Assumes pins synchronous to clk_i at 125 MHz; one clock enable.
// What this block does
// - Output pin read returns requested value, not contended pin level.
// - Output bits disable their Schmitt input stage.
// - Unused register bit per pin keeps value, no pin effect.
// - Unused register bit never changed by pin activity.
// - Output register writes take effect on rising clock edge.
// - Output register read returns the held output value.
// - Register accesses accepted in any order and spacing.
// - Direction bit 1 is output, 0 is input, at 0xD2.
// - Drive select picks push-pull or open-drain per output bit.
// - Every input path goes through a Schmitt buffer.
// - Inputs pass two clocked stages before the input register.
// - Input-register writes on input pins ignored; bit loads the synchroniser.
// - Output register bit drives the pin of an output bit.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module gpio_port
    import gpio_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Pins
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o,
    output logic [WIDTH-1:0] schmitt_en_o
);
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] odsel_q;
    logic [WIDTH-1:0] in_q;
    logic [WIDTH-1:0] sync_w;
    logic [WIDTH-1:0] pin_level_q;
    logic req_w;
    logic wr_w;
    logic hit_w;

    // Decode of the register map, used for write and for read
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == OFF_INPUT) || (a == OFF_OUTPUT) ||
            (a == OFF_DRIVE_SEL) || (a == OFF_DIRECTION) ||
            (a == OFF_PIN_LEVEL);
    endfunction : addr_hit

    // New request only when no answer is pending, so one answer per request
    assign req_w = cyc_i && stb_i && !ack_o && !err_o;
    assign hit_w = addr_hit(adr_i);
    assign wr_w = req_w && we_i && hit_w && sel_i[0];

    // Pin sampling: Schmitt buffer then two flops
    gpio_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(pin_i),
        .q_o(sync_w)
    );

    // Pad drive from registered controls
    gpio_pad #(
        .WIDTH(WIDTH)
    ) u_pad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .dir_i(dir_q),
        .out_i(out_q),
        .odsel_i(odsel_q),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o),
        .schmitt_en_o(schmitt_en_o)
    );

    // Direction register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= RST_DIRECTION;
        end else if (ce_i && wr_w && adr_i == OFF_DIRECTION) begin
            dir_q <= dat_i[WIDTH-1:0];
        end
    end

    // Drive select register, meaningful only on output bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            odsel_q <= RST_DRIVE_SEL;
        end else if (ce_i && wr_w && adr_i == OFF_DRIVE_SEL) begin
            odsel_q <= dat_i[WIDTH-1:0];
        end
    end

    // Output register: written on a clock edge, held otherwise
    // Input pins keep their output bit untouched by pin activity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= RST_OUTPUT;
        end else if (ce_i && wr_w && adr_i == OFF_OUTPUT) begin
            out_q <= dat_i[WIDTH-1:0];
        end
    end

    // Input register: input bits track the synchroniser, overwriting
    // any write; output bits keep the last written value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_q <= RST_INPUT;
        end else if (ce_i) begin
            for (int i = 0; i < WIDTH; i++) begin
                if (dir_q[i] != DIR_OUTPUT) begin
                    in_q[i] <= sync_w[i];
                end else if (wr_w && adr_i == OFF_INPUT) begin
                    in_q[i] <= dat_i[i];
                end
                // Output bits never sample the pin
            end
        end
    end

    // Raw synchronised pin level, for diagnostics only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_level_q <= '0;
        end else if (ce_i) begin
            pin_level_q <= sync_w;
        end
    end

    // Bus answer: ack one cycle after the request, err on unmapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else if (ce_i) begin
            ack_o <= req_w && hit_w;
            err_o <= req_w && !hit_w;
        end
    end

    // Read data; output register returns held value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (ce_i) begin
            dat_o <= '0;
            if (req_w && !we_i) begin
                case (adr_i)
                    OFF_INPUT: dat_o[WIDTH-1:0] <= in_q;
                    OFF_OUTPUT: dat_o[WIDTH-1:0] <= out_q;
                    OFF_DRIVE_SEL: dat_o[WIDTH-1:0] <= odsel_q;
                    OFF_DIRECTION: dat_o[WIDTH-1:0] <= dir_q;
                    OFF_PIN_LEVEL: dat_o[WIDTH-1:0] <= pin_level_q;
                    default: dat_o <= '0;
                endcase
            end
        end
    end
endmodule : gpio_port

// File: gpio_pkg.sv
// Constants for the bit-programmable I/O port.
// Assumes a 32-bit classic Wishbone register bus with byte addressing.
package gpio_pkg;
    localparam int PORT_WIDTH = 8;
    // Byte addresses of the registers
    localparam logic [7:0] OFF_INPUT = 8'h00;
    localparam logic [7:0] OFF_OUTPUT = 8'h04;
    localparam logic [7:0] OFF_DRIVE_SEL = 8'h08;
    localparam logic [7:0] OFF_DIRECTION = 8'hd2;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h0c;
    // Reset values
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OUTPUT = 8'h00;
    localparam logic [7:0] RST_DRIVE_SEL = 8'h00;
    localparam logic [7:0] RST_INPUT = 8'h00;
    // Direction bit encoding
    localparam logic DIR_OUTPUT = 1'b1;
    // Drive select encoding
    localparam logic DRV_OPEN_DRAIN = 1'b1;
    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage : gpio_pkg

// File: gpio_sync.sv
// Two-stage synchroniser for the port input pins.
// Assumes pins are sampled on clk_i with a common clock enable.
`timescale 1ns/1ps
module gpio_sync
    import gpio_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : gpio_sync

// File: gpio_pad.sv
// Per-pin drive logic: direction, push-pull or open-drain.
// Assumes registered controls; outputs are registered here.
`timescale 1ns/1ps
module gpio_pad
    import gpio_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Controls
    input wire logic [WIDTH-1:0] dir_i,
    input wire logic [WIDTH-1:0] out_i,
    input wire logic [WIDTH-1:0] odsel_i,
    // Pad
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_o,
    output logic [WIDTH-1:0] schmitt_en_o
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            // Pin drive per bit; open drain only pulls low
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pin_o[g] <= 1'b0;
                    pin_oe_o[g] <= 1'b0;
                    schmitt_en_o[g] <= 1'b1;
                end else if (ce_i) begin
                    // Input stage off on outputs to save power
                    schmitt_en_o[g] <= (dir_i[g] != DIR_OUTPUT);
                    if (dir_i[g] == DIR_OUTPUT) begin
                        if (odsel_i[g] == DRV_OPEN_DRAIN) begin
                            pin_o[g] <= 1'b0;
                            pin_oe_o[g] <= ~out_i[g];
                        end else begin
                            pin_o[g] <= out_i[g];
                            pin_oe_o[g] <= 1'b1;
                        end
                    end else begin
                        pin_o[g] <= 1'b0;
                        pin_oe_o[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule : gpio_pad

// File: gpio_port_checker.sv
// Checker for the port's bus answers and pin drive.
// Assumes it is bound to gpio_port and sees only its ports.
`timescale 1ns/1ps
module gpio_port_checker #(
    parameter int WIDTH = 8
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    // Pins
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe_o,
    input wire logic [WIDTH-1:0] schmitt_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Every request made with ce_i high is answered in the next cycle, once
    a_req_answered: assert property (
        cyc_i && stb_i && ce_i && !ack_o && !err_o |=> ack_o || err_o)
        else $error("Request not answered in one cycle");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("Acknowledge longer than one cycle");
    a_answer_excl: assert property (!(ack_o && err_o))
        else $error("Acknowledge and error together");
    a_idle_quiet: assert property (
        !(cyc_i && stb_i) |=> !ack_o && !err_o)
        else $error("Answer without a request");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
        else $error("Read data upper bytes not zero");
    // A driven pin never keeps its input stage on
    a_schmitt_driven: assert property ((pin_oe_o & schmitt_en_o) == '0)
        else $error("Input stage on while pin driven");
    // Pin drive only moves one edge after an accepted write
    a_pin_cause: assert property (
        !$stable({pin_o, pin_oe_o}) |-> $past(ack_o && we_i))
        else $error("Pin drive changed without a write");
    a_schmitt_cause: assert property (
        !$stable(schmitt_en_o) |-> $past(ack_o && we_i))
        else $error("Input stage changed without a write");
endmodule : gpio_port_checker

// File: gpio_pins_model.sv
// External circuitry on the port pins: pull-ups and a forcing source.
// Assumes the bench sets the source only between transfers.
`timescale 1ns/1ps
module gpio_pins_model (
    // From the port
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_o,
    // Forcing source, used as input stimulus or as a fault
    input wire logic [7:0] ext_val_i,
    input wire logic [7:0] ext_en_i,
    // Level seen at the pins
    output logic [7:0] level_o
);
    // Source beats the driver; a released pin floats up to the pull-up
    assign level_o = (ext_en_i & ext_val_i)
        | (~ext_en_i & ((pin_oe_o & pin_o) | ~pin_oe_o));
endmodule : gpio_pins_model

// File: gpio_port_test.sv
// Self-checking bench for the bit-programmable I/O port.
// Assumes the gpio_pkg map and a one-cycle Wishbone answer.
`timescale 1ns/1ps
module gpio_port_test import gpio_pkg::*;;
    logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
    logic [7:0] adr_i, pin_i, pin_o, pin_oe_o, schmitt_en_o;
    logic [7:0] ext_val, ext_en;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    int bad_count = 0;
    int num_checks = 0;
    gpio_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .schmitt_en_o(schmitt_en_o));
    gpio_pins_model pins (.pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin_i));
    task automatic check(input string what, input logic [31:0] s, x);
        num_checks++;
        if (s !== x) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, x, s);
        end
    endtask : check
    // One classic cycle; waits for the answer with no bound of its own
    task automatic wb(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
        sel_i <= 4'hf; dat_i <= {24'h00_0000, d};
        // Only the watchdog ends a wait that never sees an answer
        do begin
            @(posedge clk_i);
        end while (!(ack_o || err_o));
        rd = dat_o;
        e = err_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
    endtask : wb
    task automatic rdchk(input string what, input logic [7:0] a, x);
        wb(1'b0, a, 8'h00);
        check(what, rd, {24'h00_0000, x});
    endtask : rdchk
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle
    task automatic force_pins(input logic [7:0] en, v);
        @(posedge clk_i);
        ext_en <= en; ext_val <= v;
    endtask : force_pins
    task automatic t_reset;
        rdchk("dir", OFF_DIRECTION, RST_DIRECTION);
        rdchk("drv", OFF_DRIVE_SEL, RST_DRIVE_SEL);
        check("schmitt", schmitt_en_o, 8'hff);
    endtask : t_reset
    // Push-pull outputs, then a fault fighting them
    task automatic t_outputs;
        wb(1'b1, OFF_DRIVE_SEL, 8'h00);
        wb(1'b1, OFF_DIRECTION, 8'hff);
        wb(1'b1, OFF_OUTPUT, 8'ha5);
        settle;
        check("oe", pin_oe_o, 8'hff);
        check("pin", pin_o, 8'ha5);
        check("schmitt", schmitt_en_o, 8'h00);
        wb(1'b1, OFF_INPUT, 8'h3c);
        force_pins(8'hff, 8'h5a);
        settle;
        rdchk("out", OFF_OUTPUT, 8'ha5);
        rdchk("in", OFF_INPUT, 8'h3c);
        rdchk("level", OFF_PIN_LEVEL, 8'h5a);
    endtask : t_outputs
    // Open drain on the low nibble only, set as the last step
    task automatic t_open_drain;
        force_pins(8'h00, 8'h00);
        wb(1'b1, OFF_DRIVE_SEL, 8'h0f);
        settle;
        check("oe od", pin_oe_o, 8'hf0 | (~8'ha5 & 8'h0f));
        check("od low", pin_o & pin_oe_o & 8'h0f, 8'h00);
    endtask : t_open_drain
    task automatic t_inputs;
        wb(1'b1, OFF_DRIVE_SEL, 8'h00);
        wb(1'b1, OFF_DIRECTION, 8'h00);
        force_pins(8'hff, 8'hc3);
        settle;
        check("oe in", pin_oe_o, 8'h00);
        rdchk("in", OFF_INPUT, 8'hc3);
        rdchk("level in", OFF_PIN_LEVEL, 8'hc3);
        wb(1'b1, OFF_INPUT, 8'h00);
        rdchk("in wr", OFF_INPUT, 8'hc3);
        rdchk("out kept", OFF_OUTPUT, 8'ha5);
        wb(1'b0, 8'h10, 8'h00);
        check("err", e, 1'b1);
    endtask : t_inputs
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        rst_i = 1'b1; ce_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0;
        we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0000_0000;
        ext_val = 8'h00; ext_en = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_outputs;
        t_open_drain;
        t_inputs;
        results;
    end
    // Watchdog well past the 85 or so cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        results;
    end
endmodule : gpio_port_test
bind gpio_port gpio_port_checker #(.WIDTH(WIDTH)) chk (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .schmitt_en_o(schmitt_en_o));
